// ---- common/cip_pkg.sv ----
package cip_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] CIP_IDX_CTRL = 8'h00;
   localparam logic [7:0] CIP_IDX_STATUS = 8'h01;
   localparam logic [7:0] CIP_IDX_L0PTR = 8'h02;
   localparam logic [7:0] CIP_IDX_L1VEC = 8'h03;
   localparam logic [7:0] CIP_IDX_EVSTAT = 8'h04;
   localparam logic [7:0] CIP_IDX_EVMASK = 8'h05;
   localparam int CIP_ADDR_W = 8;
   localparam logic [1:0] CIP_ADDR_LSB = 2'h0;

   // Control fields
   localparam int CIP_CTRL_VBS_BIT = 6;
   localparam int CIP_CTRL_CVT_BIT = 5;
   localparam int CIP_CTRL_RR_BIT = 0;
   // Execution status fields
   localparam int CIP_ST_NMI_BIT = 7;
   localparam int CIP_ST_L1_BIT = 1;
   localparam int CIP_ST_L0_BIT = 0;
   // Event status fields
   localparam int CIP_EV_ACK_BIT = 0;
   localparam int CIP_EV_RET_BIT = 1;
   localparam int CIP_EV_NMI_BIT = 2;
   localparam int CIP_EV_W = 3;

   // Priority levels, also index into the execution bits
   localparam logic [1:0] CIP_LVL0 = 2'h0;
   localparam logic [1:0] CIP_LVL1 = 2'h1;
   localparam logic [1:0] CIP_LVL_NMI = 2'h2;

   // Compact table slots
   localparam logic [7:0] CIP_CVT_NMI = 8'h01;
   localparam logic [7:0] CIP_CVT_L1 = 8'h02;
   localparam logic [7:0] CIP_CVT_L0 = 8'h03;

   localparam logic [15:0] CIP_BOOT_START = 16'h0000;
   localparam logic [7:0] CIP_RESET_VEC = 8'h00;

   // Cycle figures of the interrupt sequence
   localparam int CIP_PUSH_CYC = 2;
   localparam int CIP_JMP_CYC = 3;
   localparam int CIP_RJMP_CYC = 2;
   localparam int CIP_WAKE_CYC = 5;
   localparam int CIP_RET_SHORT_CYC = 4;
   localparam int CIP_RET_LONG_CYC = 5;
   localparam int CIP_SMALL_FLASH_KB = 8;
   localparam int CIP_SHORT_PC_W = 16;

   typedef enum logic [2:0] {
      CIP_S_IDLE,
      CIP_S_FINISH,
      CIP_S_WAKE,
      CIP_S_PUSH,
      CIP_S_JUMP,
      CIP_S_RET,
      CIP_S_GAP
   } cip_state_t;
endpackage

// ---- src/cip_rr_pick.sv ----
`timescale 1ns/1ps
// Picks the first set request after position last, wrapping around
module cip_rr_pick #(
   parameter int N = 32
) (
   input wire logic [N-1:0] req,
   input wire logic [7:0] last,
   output logic found,
   output logic [7:0] idx
);
   always_comb
   begin
      int j;
      j = 0;
      found = 1'b0;
      idx = 8'h00;
      // Descending walk so the nearest candidate is written last
      for (int k = N; k >= 1; k--)
      begin
         j = (int'(last) + k) % N;
         if (req[j])
         begin
            found = 1'b1;
            idx = 8'(j);
         end
      end
   end
endmodule

// ---- src/cip_interrupt_prioritizer.sv ----
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Rank request against running level, else hold
// - One program instruction after return before next
// - Three levels: NMI, one level 1, level 0
// - Level 1 preempts level 0, level 0 resumes
// - Response: finish, push two, jump three/two
// - Multi-cycle instruction completes before sequence starts
// - Wake from sleep adds five plus start-up
// - Return takes four or five cycles
// - Resume at exact interrupted address
// - Peripheral flags never cleared here
// - Maskable requests only with global enable set
// - Vector fetch address follows base select
// - Base select: after boot, or boot start
// - NMI ignores enable, never preempted
// - Static level 0: lowest vector first while the pointer is 0
// - Rotation records acknowledged level 0 vector
module cip_interrupt_prioritizer
   import cip_pkg::*;
#(
   parameter int N_VEC = 32,
   parameter logic [N_VEC-1:0] NMI_MAP = 32'h0000_0002,
   parameter int FLASH_KB = 32,
   parameter int PC_W = 16,
   parameter int SLEEP_STARTUP = 0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CIP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic [N_VEC-1:0] irq_req,
   input wire logic gie,
   input wire logic insn_done,
   input wire logic core_sleep,
   input wire logic reti,
   input wire logic [PC_W-1:0] cur_pc,
   input wire logic [15:0] boot_end_addr,
   output logic int_ack,
   output logic [7:0] int_vector,
   output logic [15:0] int_vector_addr,
   output logic seq_busy,
   output logic resume_valid,
   output logic [PC_W-1:0] resume_pc
);
   localparam bit LARGE_FLASH = FLASH_KB > CIP_SMALL_FLASH_KB;
   localparam int JUMP_CYC = LARGE_FLASH ? CIP_JMP_CYC : CIP_RJMP_CYC;
   localparam int RET_CYC = (PC_W > CIP_SHORT_PC_W) ? CIP_RET_LONG_CYC : CIP_RET_SHORT_CYC;
   localparam int WAKE_TOTAL = CIP_WAKE_CYC + SLEEP_STARTUP;

   cip_state_t st_r, st_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic vbs_r, cvt_r, rr_r;
   logic [7:0] l0ptr_r, l1vec_r;
   logic [2:0] ex_r;
   logic [CIP_EV_W-1:0] ev_r, evmask_r;
   logic [1:0] sel_lvl_r;
   logic [7:0] sel_vec_r;
   logic [PC_W-1:0] saved_pc_r [3];
   logic int_ack_r, seq_busy_r, resume_valid_r, irq_r, pready_r, pslverr_r;
   logic [7:0] int_vector_r;
   logic [15:0] int_vector_addr_r;
   logic [PC_W-1:0] resume_pc_r;
   logic [31:0] prdata_r;

   // Request split by level; flags are only looked at, never cleared
   logic [N_VEC-1:0] l1_hit, nmi_req, l1_req, l0_req;
   genvar g;
   generate
      for (g = 0; g < N_VEC; g++)
      begin : g_lvl
         assign l1_hit[g] = (l1vec_r == 8'(g));
         assign nmi_req[g] = irq_req[g] && NMI_MAP[g] && (8'(g) != CIP_RESET_VEC);
         assign l1_req[g] = irq_req[g] && !NMI_MAP[g] && l1_hit[g] && (8'(g) != CIP_RESET_VEC);
         assign l0_req[g] = irq_req[g] && !NMI_MAP[g] && !l1_hit[g] && (8'(g) != CIP_RESET_VEC);
      end
   endgenerate

   logic nmi_found, l1_found, l0_found;
   logic [7:0] nmi_idx, l0_idx;
   logic [7:0] l1_idx;

   // NMI ties resolved statically, lowest vector first
   cip_rr_pick #(.N(N_VEC)) u_nmi_pick (
      .req(nmi_req),
      .last(8'(N_VEC - 1)),
      .found(nmi_found),
      .idx(nmi_idx)
   );
   // Level 0 starts after the pointer; pointer 0 gives lowest-first
   cip_rr_pick #(.N(N_VEC)) u_l0_pick (
      .req(l0_req),
      .last(l0ptr_r),
      .found(l0_found),
      .idx(l0_idx)
   );
   assign l1_found = |l1_req;
   assign l1_idx = l1vec_r;

   logic can_nmi, can_l1, can_l0, take;
   logic [1:0] win_lvl;
   logic [7:0] win_vec;
   always_comb
   begin
      can_nmi = nmi_found && !ex_r[CIP_LVL_NMI];
      can_l1 = l1_found && gie && !ex_r[CIP_LVL_NMI] && !ex_r[CIP_LVL1];
      can_l0 = l0_found && gie && (ex_r == 3'h0);
      take = can_nmi || can_l1 || can_l0;
      win_lvl = CIP_LVL0;
      win_vec = l0_idx;
      if (can_nmi)
      begin
         win_lvl = CIP_LVL_NMI;
         win_vec = nmi_idx;
      end
      else if (can_l1)
      begin
         win_lvl = CIP_LVL1;
         win_vec = l1_idx;
      end
   end

   // Sequencer of response, return and the one-instruction gap
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      case (st_r)
         CIP_S_IDLE:
         begin
            if (reti && ex_r != 3'h0)
            begin
               st_nxt = CIP_S_RET;
               cnt_nxt = 8'(RET_CYC - 1);
            end
            else if (take && core_sleep)
            begin
               st_nxt = CIP_S_WAKE;
               cnt_nxt = 8'(WAKE_TOTAL - 1);
            end
            else if (take)
            begin
               st_nxt = CIP_S_FINISH;
            end
         end
         CIP_S_FINISH:
         begin
            // Core marks the end of even a multi-cycle instruction
            if (insn_done)
            begin
               st_nxt = CIP_S_PUSH;
               cnt_nxt = 8'(CIP_PUSH_CYC - 1);
            end
         end
         CIP_S_WAKE:
         begin
            if (cnt_r == 8'h00)
            begin
               st_nxt = CIP_S_PUSH;
               cnt_nxt = 8'(CIP_PUSH_CYC - 1);
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         CIP_S_PUSH:
         begin
            if (cnt_r == 8'h00)
            begin
               st_nxt = CIP_S_JUMP;
               cnt_nxt = 8'(JUMP_CYC - 1);
            end
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         CIP_S_JUMP:
         begin
            if (cnt_r == 8'h00)
               st_nxt = CIP_S_IDLE;
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         CIP_S_RET:
         begin
            if (cnt_r == 8'h00)
               st_nxt = CIP_S_GAP;
            else
               cnt_nxt = cnt_r - 8'h01;
         end
         CIP_S_GAP:
         begin
            if (insn_done)
               st_nxt = CIP_S_IDLE;
         end
         default:
         begin
            st_nxt = CIP_S_IDLE;
            cnt_nxt = 8'h00;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= CIP_S_IDLE;
         cnt_r <= 8'h00;
         seq_busy_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         seq_busy_r <= (st_nxt != CIP_S_IDLE) && (st_nxt != CIP_S_GAP);
      end
   end

   // Winner is frozen when the sequence starts
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_lvl_r <= CIP_LVL0;
         sel_vec_r <= 8'h00;
      end
      else if (st_r == CIP_S_IDLE && st_nxt != CIP_S_IDLE && st_nxt != CIP_S_RET)
      begin
         sel_lvl_r <= win_lvl;
         sel_vec_r <= win_vec;
      end
   end

   // One saved address per level; nesting is at most three deep
   always_ff @(posedge pclk)
   begin
      if ((st_r == CIP_S_FINISH && insn_done) || (st_r == CIP_S_WAKE && cnt_r == 8'h00))
         saved_pc_r[sel_lvl_r] <= cur_pc;
   end

   logic ret_end, ack_end;
   logic [1:0] ret_lvl;
   assign ack_end = (st_r == CIP_S_JUMP) && (cnt_r == 8'h00);
   assign ret_end = (st_r == CIP_S_RET) && (cnt_r == 8'h00);
   assign ret_lvl = ex_r[CIP_LVL_NMI] ? CIP_LVL_NMI : (ex_r[CIP_LVL1] ? CIP_LVL1 : CIP_LVL0);

   logic [7:0] slot;
   logic [15:0] base;
   always_comb
   begin
      slot = sel_vec_r;
      if (cvt_r)
         slot = (sel_lvl_r == CIP_LVL_NMI) ? CIP_CVT_NMI :
                ((sel_lvl_r == CIP_LVL1) ? CIP_CVT_L1 : CIP_CVT_L0);
      base = vbs_r ? CIP_BOOT_START : boot_end_addr;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         int_ack_r <= 1'b0;
         int_vector_r <= 8'h00;
         int_vector_addr_r <= 16'h0000;
         resume_valid_r <= 1'b0;
         resume_pc_r <= '0;
         ex_r <= 3'h0;
      end
      else
      begin
         int_ack_r <= ack_end;
         resume_valid_r <= ret_end;
         if (ack_end)
         begin
            int_vector_r <= sel_vec_r;
            // Two words per slot when the vector holds a long jump
            int_vector_addr_r <= base + (LARGE_FLASH ? {7'h00, slot, 1'b0} : {8'h00, slot});
            ex_r[sel_lvl_r] <= 1'b1;
         end
         else if (ret_end)
         begin
            resume_pc_r <= saved_pc_r[ret_lvl];
            ex_r[ret_lvl] <= 1'b0;
         end
      end
   end

   // APB slave, zero wait states
   logic setup, wr_acc;
   logic [7:0] idx;
   logic mapped;
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pready_r && pwrite && !pslverr_r;
   assign idx = {2'h0, paddr[CIP_ADDR_W-1:2]};
   assign mapped = (paddr[1:0] == CIP_ADDR_LSB) && (idx <= CIP_IDX_EVMASK);

   logic [CIP_EV_W-1:0] ev_set;
   always_comb
   begin
      ev_set = '0;
      ev_set[CIP_EV_ACK_BIT] = ack_end;
      ev_set[CIP_EV_RET_BIT] = ret_end;
      ev_set[CIP_EV_NMI_BIT] = ack_end && (sel_lvl_r == CIP_LVL_NMI);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         vbs_r <= 1'b0;
         cvt_r <= 1'b0;
         rr_r <= 1'b0;
         l1vec_r <= 8'h00;
         evmask_r <= '0;
      end
      else if (wr_acc)
      begin
         if (idx == CIP_IDX_CTRL)
         begin
            vbs_r <= pwdata[CIP_CTRL_VBS_BIT];
            cvt_r <= pwdata[CIP_CTRL_CVT_BIT];
            rr_r <= pwdata[CIP_CTRL_RR_BIT];
         end
         if (idx == CIP_IDX_L1VEC)
            l1vec_r <= pwdata[7:0];
         if (idx == CIP_IDX_EVMASK)
            evmask_r <= pwdata[CIP_EV_W-1:0];
      end
   end

   // Hardware record of the acknowledged vector beats a software write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         l0ptr_r <= 8'h00;
      else if (ack_end && rr_r && sel_lvl_r == CIP_LVL0)
         l0ptr_r <= sel_vec_r;
      else if (wr_acc && idx == CIP_IDX_L0PTR)
         l0ptr_r <= pwdata[7:0];
   end

   // Sticky events, write one to clear; a new event wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ev_r <= '0;
         irq_r <= 1'b0;
      end
      else
      begin
         if (wr_acc && idx == CIP_IDX_EVSTAT)
            ev_r <= (ev_r & ~pwdata[CIP_EV_W-1:0]) | ev_set;
         else
            ev_r <= ev_r | ev_set;
         irq_r <= |(ev_r & evmask_r);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end
      else
      begin
         pready_r <= setup;
         pslverr_r <= setup && !mapped;
         if (setup)
         begin
            prdata_r <= 32'h0000_0000;
            if (mapped && !pwrite)
               case (idx)
                  CIP_IDX_CTRL:
                  begin
                     prdata_r[CIP_CTRL_VBS_BIT] <= vbs_r;
                     prdata_r[CIP_CTRL_CVT_BIT] <= cvt_r;
                     prdata_r[CIP_CTRL_RR_BIT] <= rr_r;
                  end
                  CIP_IDX_STATUS:
                  begin
                     prdata_r[CIP_ST_NMI_BIT] <= ex_r[CIP_LVL_NMI];
                     prdata_r[CIP_ST_L1_BIT] <= ex_r[CIP_LVL1];
                     prdata_r[CIP_ST_L0_BIT] <= ex_r[CIP_LVL0];
                  end
                  CIP_IDX_L0PTR: prdata_r[7:0] <= l0ptr_r;
                  CIP_IDX_L1VEC: prdata_r[7:0] <= l1vec_r;
                  CIP_IDX_EVSTAT: prdata_r[CIP_EV_W-1:0] <= ev_r;
                  CIP_IDX_EVMASK: prdata_r[CIP_EV_W-1:0] <= evmask_r;
                  default: prdata_r <= 32'h0000_0000;
               endcase
         end
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign irq = irq_r;
   assign int_ack = int_ack_r;
   assign int_vector = int_vector_r;
   assign int_vector_addr = int_vector_addr_r;
   assign seq_busy = seq_busy_r;
   assign resume_valid = resume_valid_r;
   assign resume_pc = resume_pc_r;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_push2;
      (st_r == CIP_S_PUSH)[*2] ##1 (st_r == CIP_S_JUMP);
   endsequence
   property p_push_len;
      $rose(st_r == CIP_S_PUSH) |-> s_push2;
   endproperty
   a_push_len: assert property (p_push_len) else $error("push not two cycles");
   property p_jump_ack;
      $fell(st_r == CIP_S_JUMP) |-> int_ack_r;
   endproperty
   a_jump_ack: assert property (p_jump_ack) else $error("no ack after jump");
   property p_ack_pulse;
      int_ack_r |=> !int_ack_r;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_ret_len;
      $rose(st_r == CIP_S_RET) |-> (st_r == CIP_S_RET)[*4] ##1 resume_valid_r;
   endproperty
   a_ret_len: assert property (p_ret_len) else $error("return length wrong");
   property p_gap;
      resume_valid_r |-> (st_r == CIP_S_GAP) && !int_ack_r;
   endproperty
   a_gap: assert property (p_gap) else $error("no instruction gap after return");
   property p_finish_wait;
      (st_r == CIP_S_FINISH) && !insn_done |=> (st_r == CIP_S_FINISH);
   endproperty
   a_finish_wait: assert property (p_finish_wait) else $error("left before instruction end");
   property p_wake;
      $rose(st_r == CIP_S_WAKE) |-> (st_r == CIP_S_WAKE)[*5] ##1 (st_r == CIP_S_PUSH);
   endproperty
   a_wake: assert property (p_wake) else $error("wake delay wrong");
   property p_gie_gate;
      (st_r != CIP_S_IDLE) && ($past(st_r) == CIP_S_IDLE) && (st_r != CIP_S_RET)
         && (sel_lvl_r != CIP_LVL_NMI) |-> $past(gie);
   endproperty
   a_gie_gate: assert property (p_gie_gate) else $error("maskable taken with enable clear");
   property p_nmi_ex;
      int_ack_r && (sel_lvl_r == CIP_LVL_NMI) |-> ex_r[CIP_LVL_NMI] && ev_r[CIP_EV_NMI_BIT];
   endproperty
   a_nmi_ex: assert property (p_nmi_ex) else $error("nmi not marked executing");
   property p_rr_update;
      int_ack_r && rr_r && (sel_lvl_r == CIP_LVL0) |-> l0ptr_r == int_vector_r;
   endproperty
   a_rr_update: assert property (p_rr_update) else $error("pointer not updated");
endmodule

// ---- tb/cip_core_model.sv ----
`timescale 1ns/1ps
// Core stand-in: steps the PC, sleeps and returns on command
module cip_core_model
   import cip_pkg::*;
#(
   parameter int PC_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic go_sleep,
   input wire logic ret_cmd,
   input wire logic seq_busy,
   input wire logic int_ack,
   input wire logic [15:0] int_vector_addr,
   input wire logic resume_valid,
   input wire logic [PC_W-1:0] resume_pc,
   output logic insn_done,
   output logic core_sleep,
   output logic reti,
   output logic [PC_W-1:0] cur_pc
);
   logic [1:0] div_r;
   // Slow mode runs three-cycle instructions, done on the last cycle
   assign insn_done = !core_sleep && (!slow || div_r == 2'h2);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_r <= 2'h0;
         core_sleep <= 1'b0;
         reti <= 1'b0;
         cur_pc <= '0;
      end
      else
      begin
         div_r <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
         reti <= ret_cmd;
         if (go_sleep) core_sleep <= 1'b1;
         else if (int_ack) core_sleep <= 1'b0;
         // PC frozen while a sequence runs, so the saved PC is stable
         if (int_ack) cur_pc <= int_vector_addr[PC_W-1:0];
         else if (resume_valid) cur_pc <= resume_pc;
         else if (insn_done && !seq_busy) cur_pc <= cur_pc + 1'b1;
      end
   end
endmodule

// ---- tb/cip_interrupt_prioritizer_test.sv ----
`timescale 1ns/1ps
module cip_interrupt_prioritizer_test import cip_pkg::*;;
   localparam int FK = 32;
   localparam int SUP = 0;
   localparam int JMP = (FK > CIP_SMALL_FLASH_KB) ? CIP_JMP_CYC : CIP_RJMP_CYC;
   localparam int LAT = 3 + CIP_PUSH_CYC + JMP;
   localparam int LATS = 2 + CIP_WAKE_CYC + SUP + CIP_PUSH_CYC + JMP;
   localparam int RETL = 1 + CIP_RET_SHORT_CYC;
   typedef struct {logic [7:0] vec; logic [15:0] addr; int lo; int hi; int t0; bit cv;} cip_note_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, gie, insn_done;
   logic core_sleep, reti, int_ack, seq_busy, resume_valid, slow, go_sleep, ret_cmd;
   logic [7:0] paddr, int_vector, l1v;
   logic [31:0] pwdata, prdata, irq_req;
   logic [15:0] cur_pc, boot_end_addr, int_vector_addr, resume_pc;
   int error_cnt = 0, n_compared = 0, cyc = 0, n_ack = 0, n_res = 0, t_r = 0, since_ret = 99;
   int v;
   bit vbs, compact_vector_mode;
   cip_note_t nq[$];
   cip_note_t nt;
   logic [15:0] stk[$], rq[$];

   cip_interrupt_prioritizer #(.FLASH_KB(FK), .SLEEP_STARTUP(SUP)) uut (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .irq_req(irq_req), .gie(gie), .insn_done(insn_done), .core_sleep(core_sleep),
      .reti(reti), .cur_pc(cur_pc), .boot_end_addr(boot_end_addr), .int_ack(int_ack),
      .int_vector(int_vector), .int_vector_addr(int_vector_addr), .seq_busy(seq_busy),
      .resume_valid(resume_valid), .resume_pc(resume_pc));
   cip_core_model core (.pclk(pclk), .presetn(presetn), .slow(slow), .go_sleep(go_sleep),
      .ret_cmd(ret_cmd), .seq_busy(seq_busy), .int_ack(int_ack),
      .int_vector_addr(int_vector_addr), .resume_valid(resume_valid), .resume_pc(resume_pc),
      .insn_done(insn_done), .core_sleep(core_sleep), .reti(reti), .cur_pc(cur_pc));

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Counted off the falling edge, away from the sampling edge, so both processes read one value
   always @(negedge pclk) cyc++;

   task automatic check(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1)
      begin
         error_cnt++;
         $display("mismatch t=%0t %s", $time, m);
      end
   endtask

   function automatic logic [15:0] va(input int v);
      logic [15:0] b, s;
      b = vbs ? CIP_BOOT_START : boot_end_addr;
      s = !compact_vector_mode ? 16'(v) : (v == 1) ? 16'(CIP_CVT_NMI) : (v == l1v) ? 16'(CIP_CVT_L1)
         : 16'(CIP_CVT_L0);
      return b + s * ((FK > CIP_SMALL_FLASH_KB) ? 16'h0002 : 16'h0001);
   endfunction

   task automatic note(input int v, input int lo, input int hi);
      cip_note_t n;
      n.vec = v[7:0];
      n.addr = va(v);
      n.lo = lo;
      n.hi = hi;
      n.t0 = cyc;
      n.cv = !compact_vector_mode;
      nq.push_back(n);
   endtask

   task automatic wait_for(input bit res);
      int base, n;
      base = res ? n_res : n_ack;
      n = 0;
      while ((res ? n_res : n_ack) == base && n < 300)
      begin
         @(posedge pclk);
         n++;
      end
      check(n < 300, "handshake timeout");
   endtask

   task automatic fire(input logic [31:0] m, input int v, input int lo, input int hi);
      @(posedge pclk);
      note(v, lo, hi);
      irq_req <= irq_req | m;
      wait_for(0);
   endtask

   task automatic clr(input logic [31:0] m);
      @(posedge pclk);
      irq_req <= irq_req & ~m;
   endtask

   task automatic do_ret(input int nv);
      @(posedge pclk);
      if (stk.size() > 0) rq.push_back(stk.pop_back());
      if (nv > 0) note(nv, 0, 999);
      ret_cmd <= 1'b1;
      @(posedge pclk);
      ret_cmd <= 1'b0;
      wait_for(1);
      if (nv > 0) wait_for(0);
   endtask

   task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
      input logic [31:0] e, input logic ee);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {i[5:0], 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      check(pready === 1'b1 && pslverr === ee, "apb ready or error flag");
      if (!w) check(prdata === e, "apb read data");
   endtask

   task automatic rd(input logic [7:0] i, input logic [31:0] e);
      apb(1'b0, i, 32'h0, e, 1'b0);
   endtask

   task automatic wr(input logic [7:0] i, input logic [31:0] d);
      apb(1'b1, i, d, 32'h0, 1'b0);
   endtask

   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask

   task automatic wrap_up;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      if (presetn === 1'b1)
      begin
         if (int_ack === 1'b1)
         begin
            stk.push_back(cur_pc);
            n_ack <= n_ack + 1;
            check(nq.size() > 0, "ack with nothing eligible");
            if (nq.size() > 0)
            begin
               nt = nq.pop_front();
               check(cyc - nt.t0 >= nt.lo && cyc - nt.t0 <= nt.hi, "ack latency");
               check(!nt.cv || int_vector === nt.vec, "vector number");
               check(int_vector_addr === nt.addr, "vector address");
               check(since_ret >= 2, "ack too soon after return");
               check(seq_busy === 1'b0, "busy at ack");
            end
         end
         if (reti === 1'b1) t_r = cyc;
         if (resume_valid === 1'b1)
         begin
            n_res <= n_res + 1;
            check(rq.size() > 0 && resume_pc === rq.pop_front(), "resume address");
            check(cyc - t_r == RETL, "return length");
         end
         // Only instructions run outside a sequence count toward the gap
         since_ret = (resume_valid === 1'b1) ? int'(insn_done)
            : since_ret + int'(insn_done && !seq_busy);
      end
   end

   initial
   begin
      #300000;
      error_cnt++;
      $display("mismatch t=%0t watchdog expired", $time);
      wrap_up();
   end

   initial
   begin
      {presetn, psel, penable, pwrite, gie, slow, go_sleep, ret_cmd} = '0;
      {paddr, pwdata, irq_req, boot_end_addr, l1v, vbs, compact_vector_mode} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      v = $urandom(32'h3c56);
      for (int i = 0; i < 6; i++) rd(i[7:0], 32'h0);
      apb(1'b0, 8'h06, 32'h0, 32'h0, 1'b1);
      wr(CIP_IDX_STATUS, 32'hFF);
      rd(CIP_IDX_STATUS, 32'h0);
      tdone("registers");
      boot_end_addr <= 16'($urandom) & 16'hFFF0;
      wr(CIP_IDX_EVMASK, 32'h4);
      @(posedge pclk);
      irq_req <= 32'h20;
      repeat (20) @(posedge pclk);
      fire(32'h2, 1, LAT, LAT);
      rd(CIP_IDX_STATUS, 32'h80);
      check(irq === 1'b1, "event interrupt raised");
      wr(CIP_IDX_EVSTAT, 32'h4);
      repeat (3) @(posedge pclk);
      check(irq === 1'b0, "event interrupt cleared");
      clr(32'h2);
      do_ret(0);
      rd(CIP_IDX_EVSTAT, 32'h3);
      wr(CIP_IDX_EVSTAT, 32'h7);
      rd(CIP_IDX_EVSTAT, 32'h0);
      wr(CIP_IDX_EVMASK, 32'h0);
      @(posedge pclk);
      note(5, LAT, LAT);
      gie <= 1'b1;
      wait_for(0);
      rd(CIP_IDX_STATUS, 32'h1);
      check(irq === 1'b0, "masked event stays quiet");
      do_ret(5);
      clr(32'h20);
      do_ret(0);
      tdone("enable and nmi");
      fire(32'h0010_0210, 4, LAT, LAT);
      clr(32'h10);
      do_ret(9);
      clr(32'h200);
      do_ret(20);
      clr(32'h0010_0000);
      do_ret(0);
      tdone("static");
      wr(CIP_IDX_CTRL, 32'h1);
      fire(32'h88, 3, LAT, LAT);
      do_ret(7);
      rd(CIP_IDX_L0PTR, 32'h7);
      clr(32'h88);
      do_ret(0);
      wr(CIP_IDX_CTRL, 32'h0);
      wr(CIP_IDX_L0PTR, 32'h0);
      tdone("rotation");
      l1v = 8'h0C;
      wr(CIP_IDX_L1VEC, 32'h0000_000C);
      fire(32'h40, 6, LAT, LAT);
      @(posedge pclk);
      irq_req <= irq_req | 32'h400;
      fire(32'h1000, 12, LAT, LAT);
      rd(CIP_IDX_STATUS, 32'h3);
      clr(32'h1000);
      do_ret(0);
      clr(32'h40);
      do_ret(10);
      clr(32'h400);
      do_ret(0);
      tdone("preemption");
      @(posedge pclk);
      go_sleep <= 1'b1;
      @(posedge pclk);
      go_sleep <= 1'b0;
      fire(32'h100, 8, LATS, LATS);
      clr(32'h100);
      do_ret(0);
      @(posedge pclk);
      slow <= 1'b1;
      fire(32'h800, 11, LAT, LAT + 2);
      clr(32'h800);
      do_ret(0);
      slow <= 1'b0;
      tdone("timing");
      vbs = 1'b1;
      wr(CIP_IDX_CTRL, 32'h40);
      fire(32'h2000, 13, LAT, LAT);
      clr(32'h2000);
      do_ret(0);
      compact_vector_mode = 1'b1;
      wr(CIP_IDX_CTRL, 32'h60);
      fire(32'h4000, 14, LAT, LAT);
      clr(32'h4000);
      do_ret(0);
      fire(32'h1000, 12, LAT, LAT);
      clr(32'h1000);
      do_ret(0);
      {vbs, compact_vector_mode} = 2'b00;
      wr(CIP_IDX_CTRL, 32'h0);
      tdone("vector placement");
      for (int k = 0; k < 4; k++)
      begin
         v = 2 + $urandom % 30;
         if (v == 12) v = 13;
         @(posedge pclk);
         boot_end_addr <= 16'($urandom) & 16'hFFF0;
         fire(32'h1 << v, v, LAT, LAT);
         clr(32'h1 << v);
         do_ret(0);
      end
      tdone("random vectors");
      wrap_up();
   end
endmodule
